/* File: rtl/msc_defs_defs.svh */
// register map, field positions, reset values of the monitor register bank
// assumes a 32-bit apb slave where each byte register takes one word
`ifndef MSC_DEFS_DEFS_SVH
`define MSC_DEFS_DEFS_SVH

// six groups of six byte registers, word 0 upward
`define MSC_GRP_BYTES 6
`define MSC_GRP_WORDS 36
`define MSC_LAST_BYTE 3'h5
// own registers above the groups
`define MSC_OFF_CFG 8'h90
`define MSC_OFF_IRQ_STAT 8'h94
`define MSC_OFF_IRQ_MASK 8'h98
// configuration word fields
`define MSC_CFG_GPIO_LSB 0
`define MSC_CFG_GPIO_W 9
`define MSC_CFG_HOLD_BIT 9
`define MSC_CFG_DTMR_BIT 10
`define MSC_CFG_MUTE_BIT 11
// status B last byte fields and flag pair base
`define MSC_REV_LSB 44
`define MSC_RSVD_LSB 42
`define MSC_MUX_BIT 41
`define MSC_THERM_BIT 40
`define MSC_FLAG_LSB 16
// reset values
`define MSC_GPIO_PD_RST 9'h000
`define MSC_IRQ_RST 4'h0
// interrupt event bits
`define MSC_IRQ_W 4
`define MSC_IRQ_NEW 0
`define MSC_IRQ_THERM 1
`define MSC_IRQ_MUX 2
`define MSC_IRQ_SEQ 3

`endif

/* File: rtl/msc_grp_store.sv */
// one six-byte read/write group, loaded whole
// assumes the caller assembles all six bytes before load
module msc_grp_store
    import msc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [47:0] din,
    output logic [47:0] dout
);
    logic [47:0] data_q;

    // whole-group commit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= 48'h000000000000;
        end else if (load) begin
            data_q <= din;
        end
    end

    assign dout = data_q;
endmodule // msc_grp_store

/* File: rtl/msc_irq.sv */
// sticky event status, mask and one level interrupt
// assumes read-clear strobe comes where the read data is taken
`include "msc_defs_defs.svh"
module msc_irq
    import msc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] evt,
    input wire logic stat_rd,
    input wire logic mask_wr,
    input wire logic [3:0] mask_din,
    output logic [3:0] stat,
    output logic [3:0] mask,
    output logic irq
);
    logic [3:0] stat_q;
    logic [3:0] mask_q;
    logic [3:0] stat_d;
    logic irq_q;

    // new events win over a read clear
    assign stat_d = (stat_rd ? `MSC_IRQ_RST : stat_q) | evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= `MSC_IRQ_RST;
            mask_q <= `MSC_IRQ_RST;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            if (mask_wr) begin
                mask_q <= mask_din;
            end
            irq_q <= |(stat_d & (mask_wr ? mask_din : mask_q));
        end
    end

    assign stat = stat_q;
    assign mask = mask_q;
    assign irq = irq_q;
endmodule // msc_irq

/* File: rtl/msc_pkg.sv */
// types shared by the monitor register bank
// assumes nothing beyond the defs header
package msc_pkg;
    // one-hot register group select
    typedef enum logic [5:0] {
        MSC_G_STA_A = 6'h01,
        MSC_G_STA_B = 6'h02,
        MSC_G_SER = 6'h04,
        MSC_G_PIN = 6'h08,
        MSC_G_BAL = 6'h10,
        MSC_G_DPB = 6'h20
    } msc_grp_t;
endpackage

/* File: rtl/msc_regs.sv */
// monitor status/control register bank with apb slave
// assumes results, flags and pin levels are synchronous to pclk
`include "msc_defs_defs.svh"
module msc_regs
    import msc_pkg::*;
#(
    parameter logic [3:0] REV_CODE = 4'h1 // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic results_load,
    input wire logic [15:0] cell_sum_result,
    input wire logic [15:0] die_temperature_result,
    input wire logic [15:0] analog_supply_result,
    input wire logic [15:0] digital_supply_result,
    input wire logic [11:0] cell_under_limit_flag,
    input wire logic [11:0] cell_over_limit_flag,
    input wire logic mux_selftest_fail_flag,
    input wire logic thermal_shutdown_flag,
    input wire logic [8:0] gpio_level,
    output logic [8:0] gpio_pulldown_on,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic watchdog_timeout,
    output logic ref_powered,
    input wire logic discharge_timer_enabled,
    input wire logic mute_active,
    output logic [47:0] serial_master_group,
    output logic [47:0] pin_pulse_group,
    output logic [47:0] balance_duty_group,
    output logic [47:0] duty_pulse_b_group
);
    logic [15:0] sum_q, dtemp_q, asup_q, dsup_q;
    logic [11:0] uv_q, ov_q;
    logic [47:0] sta_a, sta_b, live, snap_q, commit_data;
    logic [39:0] stage_q;
    logic [31:0] prdata_q, rdata_d;
    logic [23:0] flags;
    logic [8:0] gpio_pd_q;
    logic [5:0] w_idx;
    logic [3:0] evt, irq_stat, irq_mask;
    logic [2:0] grp_n, byte_n, stage_next_q;
    msc_grp_t grp, snap_grp_q, stage_grp_q;
    logic mux_q, therm_q, in_grp, acc1, wr_go, is_rw, seq_ok, commit;
    logic pready_q, pslverr_q, err_d, hold_q, ref_q, stage_vld_q;

    // address split into group and byte
    assign w_idx = paddr[7:2];
    assign grp_n = 3'(w_idx / 6'd6);
    assign byte_n = 3'(w_idx % 6'd6);
    assign in_grp = (w_idx < 6'(`MSC_GRP_WORDS));
    assign grp = msc_grp_t'(6'h01 << grp_n);
    assign is_rw = in_grp && !(grp inside {MSC_G_STA_A, MSC_G_STA_B});

    // bus phases: one wait state, then sample
    assign acc1 = psel && penable && !pready_q;
    assign wr_go = psel && penable && pready_q && pwrite;

    assign sta_a = {asup_q, dtemp_q, sum_q};

    for (genvar i = 0; i < 12; i++) begin : g_flags
        assign flags[2*i] = uv_q[i];
        assign flags[2*i+1] = ov_q[i];
    end

    // supply then flags / last byte
    assign sta_b = {REV_CODE, 2'b00, mux_q, therm_q, flags, dsup_q};

    // stored measurement results, loaded by the front end only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_q <= 16'h0000;
            dtemp_q <= 16'h0000;
            asup_q <= 16'h0000;
            dsup_q <= 16'h0000;
            uv_q <= 12'h000;
            ov_q <= 12'h000;
            mux_q <= 1'b0;
            therm_q <= 1'b0;
        end else if (results_load) begin
            sum_q <= cell_sum_result;
            dtemp_q <= die_temperature_result;
            asup_q <= analog_supply_result;
            dsup_q <= digital_supply_result;
            uv_q <= cell_under_limit_flag;
            ov_q <= cell_over_limit_flag;
            mux_q <= mux_selftest_fail_flag;
            therm_q <= thermal_shutdown_flag;
        end
    end

    // live bytes of the addressed status group
    assign live = (grp == MSC_G_STA_A) ? sta_a : sta_b;

    // byte 0 read freezes the group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_q <= 48'h000000000000;
            snap_grp_q <= MSC_G_STA_A;
        end else if (acc1 && !pwrite && in_grp && !is_rw
                     && byte_n == 3'h0) begin
            snap_q <= live;
            snap_grp_q <= grp;
        end
    end

    assign seq_ok = (byte_n == 3'h0) || (stage_vld_q
                    && stage_grp_q == grp && byte_n == stage_next_q);
    assign commit = wr_go && is_rw && seq_ok
                    && byte_n == `MSC_LAST_BYTE;
    assign commit_data = {pwdata[7:0], stage_q};

    // staging of bytes 0 to 4 until the last byte arrives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_q <= 40'h0000000000;
            stage_grp_q <= MSC_G_SER;
            stage_next_q <= 3'h0;
            stage_vld_q <= 1'b0;
        end else if (wr_go && is_rw) begin
            if (seq_ok && byte_n != `MSC_LAST_BYTE) begin
                stage_q[8*byte_n +: 8] <= pwdata[7:0];
                stage_grp_q <= grp;
                stage_next_q <= byte_n + 3'h1;
                stage_vld_q <= 1'b1;
            end else begin
                stage_vld_q <= 1'b0;
            end
        end
    end

    msc_grp_store u_ser (
        .pclk(pclk),
        .presetn(presetn),
        .load(commit && grp == MSC_G_SER),
        .din(commit_data),
        .dout(serial_master_group)
    );

    // pin pulse nibbles 1 to 12
    msc_grp_store u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .load(commit && grp == MSC_G_PIN),
        .din(commit_data),
        .dout(pin_pulse_group)
    );

    // balance duty nibbles 1 to 12
    msc_grp_store u_bal (
        .pclk(pclk),
        .presetn(presetn),
        .load(commit && grp == MSC_G_BAL),
        .din(commit_data),
        .dout(balance_duty_group)
    );

    // duty and pulse cells 13 to 18
    msc_grp_store u_dpb (
        .pclk(pclk),
        .presetn(presetn),
        .load(commit && grp == MSC_G_DPB),
        .din(commit_data),
        .dout(duty_pulse_b_group)
    );

    // read data and error decision in the first access cycle
    always_comb begin
        rdata_d = 32'h00000000;
        err_d = 1'b0;
        if (in_grp) begin
            unique case (grp)
                MSC_G_STA_A, MSC_G_STA_B: begin
                    if (byte_n != 3'h0 && snap_grp_q == grp) begin
                        rdata_d[7:0] = snap_q[8*byte_n +: 8];
                    end else begin
                        rdata_d[7:0] = live[8*byte_n +: 8];
                    end
                end
                MSC_G_SER: rdata_d[7:0] = serial_master_group[8*byte_n +: 8];
                MSC_G_PIN: rdata_d[7:0] = pin_pulse_group[8*byte_n +: 8];
                MSC_G_BAL: rdata_d[7:0] = balance_duty_group[8*byte_n +: 8];
                MSC_G_DPB: rdata_d[7:0] = duty_pulse_b_group[8*byte_n +: 8];
            endcase
            err_d = pwrite && is_rw && !seq_ok;
        end else if (paddr == `MSC_OFF_CFG) begin
            rdata_d[`MSC_CFG_GPIO_LSB +: `MSC_CFG_GPIO_W] = gpio_level;
            rdata_d[`MSC_CFG_HOLD_BIT] = hold_q;
            rdata_d[`MSC_CFG_DTMR_BIT] = discharge_timer_enabled;
            rdata_d[`MSC_CFG_MUTE_BIT] = mute_active;
        end else if (paddr == `MSC_OFF_IRQ_STAT) begin
            rdata_d[3:0] = irq_stat;
        end else if (paddr == `MSC_OFF_IRQ_MASK) begin
            rdata_d[3:0] = irq_mask;
        end else begin
            err_d = 1'b1; // unmapped
        end
    end

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc1;
            pslverr_q <= acc1 && err_d;
            if (acc1 && !pwrite) begin
                prdata_q <= rdata_d;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_pd_q <= `MSC_GPIO_PD_RST;
            hold_q <= 1'b0;
        end else if (wr_go && paddr == `MSC_OFF_CFG) begin
            gpio_pd_q <= ~pwdata[`MSC_CFG_GPIO_LSB +: `MSC_CFG_GPIO_W];
            hold_q <= pwdata[`MSC_CFG_HOLD_BIT];
        end
    end

    // reference power: up at conversion start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q <= 1'b0;
        end else if (watchdog_timeout) begin
            ref_q <= 1'b0;
        end else if (conv_start) begin
            ref_q <= 1'b1;
        end else if (conv_done && !hold_q) begin
            ref_q <= 1'b0;
        end
    end

    // events: new results, thermal and mux rising, sequence error
    assign evt[`MSC_IRQ_NEW] = results_load;
    assign evt[`MSC_IRQ_THERM] = results_load && thermal_shutdown_flag
                                 && !therm_q;
    assign evt[`MSC_IRQ_MUX] = results_load && mux_selftest_fail_flag
                               && !mux_q;
    assign evt[`MSC_IRQ_SEQ] = wr_go && is_rw && !seq_ok;

    // read clear on the data-take edge, so no event slips in unread
    msc_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .evt(evt),
        .stat_rd(acc1 && !pwrite && paddr == `MSC_OFF_IRQ_STAT),
        .mask_wr(wr_go && paddr == `MSC_OFF_IRQ_MASK),
        .mask_din(pwdata[3:0]),
        .stat(irq_stat),
        .mask(irq_mask),
        .irq(irq)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign gpio_pulldown_on = gpio_pd_q;
    assign ref_powered = ref_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_rd_first(logic [7:0] a);
        acc1 && !pwrite && paddr == a;
    endsequence

    sequence s_wr_first(logic [7:0] a);
        acc1 && pwrite && paddr == a;
    endsequence

    property p_sta_a_low;
        s_rd_first(8'h00) |=> pready && prdata[7:0] == $past(sum_q[7:0]);
    endproperty
    a_sta_a_low: assert property (p_sta_a_low)
        else $error("status A byte 0 not cell sum low");

    property p_flag_pair;
        results_load |=> sta_b[17:16] == {$past(cell_over_limit_flag[0]),
            $past(cell_under_limit_flag[0])}
            && sta_b[15:0] == $past(digital_supply_result);
    endproperty
    a_flag_pair: assert property (p_flag_pair)
        else $error("status B supply or flag pair misplaced");

    property p_high_pair;
        sta_b[39:38] == {ov_q[11], uv_q[11]};
    endproperty
    a_high_pair: assert property (p_high_pair)
        else $error("cell 12 flag pair misplaced");

    property p_last_byte;
        sta_b[47:40] == {REV_CODE, 2'b00, mux_q, therm_q};
    endproperty
    a_last_byte: assert property (p_last_byte)
        else $error("status B last byte wrong");

    property p_ser_commit;
        wr_go && is_rw && seq_ok && grp == MSC_G_SER && byte_n == 3'h5
        |=> serial_master_group[47:40] == $past(pwdata[7:0]);
    endproperty
    a_ser_commit: assert property (p_ser_commit)
        else $error("serial master group not committed");

    property p_gpio_pd;
        s_wr_first(`MSC_OFF_CFG) ##1 wr_go |=>
            gpio_pulldown_on == ~$past(pwdata[8:0]);
    endproperty
    a_gpio_pd: assert property (p_gpio_pd)
        else $error("gpio pull-down not inverse of written bit");

    property p_gpio_rd;
        s_rd_first(`MSC_OFF_CFG) |=> prdata[8:0] == $past(gpio_level)
            && prdata[10] == $past(discharge_timer_enabled)
            && prdata[11] == $past(mute_active);
    endproperty
    a_gpio_rd: assert property (p_gpio_rd)
        else $error("config read does not show pin and status levels");

    property p_ref_hold;
        hold_q && ref_q && !watchdog_timeout |=> ref_powered;
    endproperty
    a_ref_hold: assert property (p_ref_hold)
        else $error("reference dropped while held");

    property p_ref_off;
        conv_done && !hold_q && !conv_start |=> !ref_powered;
    endproperty
    a_ref_off: assert property (p_ref_off)
        else $error("reference stayed up after conversion");

    property p_sta_ignore;
        wr_go && in_grp && !is_rw && !results_load |=> $stable(sum_q)
            && $stable(dsup_q) && $stable(uv_q);
    endproperty
    a_sta_ignore: assert property (p_sta_ignore)
        else $error("status group changed by a bus write");

    property p_seq_err;
        acc1 && pwrite && is_rw && byte_n != 3'h0 && !stage_vld_q
        |=> pready && pslverr ##1 !pready;
    endproperty
    a_seq_err: assert property (p_seq_err)
        else $error("out of order group write not refused");
endmodule // msc_regs

/* File: verification/msc_afe_model.sv */
// behavioural measurement front end feeding the register bank
// assumes conv_start is a one-cycle pulse; results settle before load
module msc_afe_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_start,
    output logic conv_done,
    output logic results_load,
    output logic [15:0] cs,
    output logic [15:0] dt,
    output logic [15:0] as_v,
    output logic [15:0] ds,
    output logic [11:0] uv,
    output logic [11:0] ov,
    output logic mux,
    output logic th
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_q;
    logic busy_q;
    logic [3:0] k_q;

    // conversion takes three cycles, then load and done pulse together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            cnt_q <= 2'h0;
            k_q <= 4'h0;
            conv_done <= 1'b0;
            results_load <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            results_load <= 1'b0;
            if (conv_start) begin
                busy_q <= 1'b1;
                cnt_q <= 2'h2;
            end else if (busy_q && cnt_q == 2'h0) begin
                busy_q <= 1'b0;
                conv_done <= 1'b1;
                results_load <= 1'b1;
                k_q <= k_q + 4'h1;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end

    // results follow the conversion count so every run differs
    assign cs = 16'h1357 + {12'h000, k_q};
    assign dt = 16'h2468 + {12'h000, k_q};
    assign as_v = 16'h9ABC + {12'h000, k_q};
    assign ds = 16'hDEF0 + {12'h000, k_q};
    assign uv = 12'h5A3 ^ {8'h00, k_q};
    assign ov = 12'hC3C ^ {8'h00, k_q};
    assign mux = k_q[0];
    assign th = k_q[1];
endmodule // msc_afe_model

/* File: verification/tb.sv */
// apb testbench of the monitor register bank
// assumes the front-end model drives results; bench drives the rest
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, rl, mux, th, cdone, refp;
    logic cstart = 1'b0;
    logic wdt = 1'b0;
    logic dtmr_en = 1'b1;
    logic mute = 1'b0;
    logic [15:0] cs, dt, as_v, ds;
    logic [11:0] uv, ov;
    logic [8:0] glev = 9'h0A5;
    logic [8:0] gpd;
    logic [47:0] go [2:5];
    logic [47:0] v, x;
    logic [31:0] r;
    logic e;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;

    msc_afe_model afe (.pclk(pclk), .presetn(presetn),
        .conv_start(cstart), .conv_done(cdone), .results_load(rl),
        .cs(cs), .dt(dt), .as_v(as_v), .ds(ds), .uv(uv), .ov(ov),
        .mux(mux), .th(th));

    msc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .results_load(rl),
        .cell_sum_result(cs), .die_temperature_result(dt),
        .analog_supply_result(as_v), .digital_supply_result(ds),
        .cell_under_limit_flag(uv), .cell_over_limit_flag(ov),
        .mux_selftest_fail_flag(mux), .thermal_shutdown_flag(th),
        .gpio_level(glev), .gpio_pulldown_on(gpd),
        .conv_start(cstart), .conv_done(cdone),
        .watchdog_timeout(wdt), .ref_powered(refp),
        .discharge_timer_enabled(dtmr_en), .mute_active(mute),
        .serial_master_group(go[2]), .pin_pulse_group(go[3]),
        .balance_duty_group(go[4]), .duty_pulse_b_group(go[5]));

    // clock at 25 MHz
    initial begin
        forever #20 pclk = ~pclk;
    end

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard over the whole run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [47:0] ex,
                       input logic [47:0] got);
        n_compared++;
        if (got !== ex) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // one apb transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_count++;
        end
    endtask

    // whole group moves byte 0 upward
    task automatic wgrp(input int g, input logic [47:0] d);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, 8'(4 * (6 * g + k)), {24'h0, d[8*k+:8]});
        end
    endtask

    task automatic rgrp(input int g, output logic [47:0] d);
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, 8'(4 * (6 * g + k)), 32'h0);
            d[8*k+:8] = r[7:0];
        end
    endtask

    task automatic conv;
        @(posedge pclk);
        cstart <= 1'b1;
        @(posedge pclk);
        cstart <= 1'b0;
        #1 chk("ref on", 48'h1, {47'h0, refp});
        repeat (6) @(posedge pclk);
        #1;
    endtask

    function automatic logic [47:0] stat_b;
        logic [23:0] fl;
        for (int i = 0; i < 12; i++) begin
            fl[2*i] = uv[i];
            fl[2*i+1] = ov[i];
        end
        return {4'h1, 2'b00, mux, th, fl, ds};
    endfunction

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk("pulldown reset", 48'h0, {39'h0, gpd});
        chk("ref reset", 48'h0, {47'h0, refp});
        conv();
        chk("ref after conv", 48'h0, {47'h0, refp});
        rgrp(0, x);
        chk("status a", {as_v, dt, cs}, x);
        rgrp(1, x);
        v = stat_b();
        chk("status b", v, x & 48'hF3FF_FFFF_FFFF);
        wgrp(0, ~{as_v, dt, cs});
        rgrp(0, x);
        chk("status a kept", {as_v, dt, cs}, x);
        chk("irq masked", 48'h0, {47'h0, irq});
        apb(1'b0, 8'h94, 32'h0);
        chk("irq stat", 48'h5, {44'h0, r[3:0]});
        // every read/write group, committed on byte 5
        for (int g = 2; g < 6; g++) begin
            v = {6{8'(8'h11 * g)}} ^ 48'h0123_4567_89AB;
            wgrp(g, v);
            @(posedge pclk);
            #1 chk("group out", v, go[g]);
            rgrp(g, x);
            chk("group read", v, x);
        end
        apb(1'b1, 8'h98, 32'h8);
        apb(1'b1, 8'h30, 32'h77);
        apb(1'b1, 8'h38, 32'h66);
        chk("order error", 48'h1, {47'h0, e});
        // a later byte with nothing staged is refused as well
        apb(1'b1, 8'h34, 32'h55);
        chk("order error 2", 48'h1, {47'h0, e});
        v = {6{8'h22}} ^ 48'h0123_4567_89AB;
        chk("group unchanged", v, go[2]);
        @(posedge pclk);
        #1 chk("irq raised", 48'h1, {47'h0, irq});
        apb(1'b0, 8'h94, 32'h0);
        chk("irq stat seq", 48'h8, {44'h0, r[3:0]});
        @(posedge pclk);
        #1 chk("irq cleared", 48'h0, {47'h0, irq});
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped err", 48'h1, {47'h0, e});
        chk("unmapped data", 48'h0, {16'h0, r});
        // pull-downs, pin read-back and read-only bits
        apb(1'b1, 8'h90, 32'h0000_0C3A);
        @(posedge pclk);
        #1 chk("pulldown", 48'h1C5, {39'h0, gpd});
        apb(1'b0, 8'h90, 32'h0);
        chk("cfg read", 48'h4A5, {36'h0, r[11:0]});
        glev <= 9'h15A;
        dtmr_en <= 1'b0;
        mute <= 1'b1;
        apb(1'b0, 8'h90, 32'h0);
        chk("cfg read 2", 48'h95A, {36'h0, r[11:0]});
        // reference hold until the watchdog
        apb(1'b1, 8'h90, 32'h0000_03FF);
        conv();
        chk("ref held", 48'h1, {47'h0, refp});
        @(posedge pclk);
        wdt <= 1'b1;
        @(posedge pclk);
        wdt <= 1'b0;
        @(posedge pclk);
        #1 chk("ref watchdog", 48'h0, {47'h0, refp});
        test_done();
    end
endmodule // tb
